// >>> rtl/motor_opt_defs.svh
// Offsets, field positions, reset values and timing figures of the option registers.
// Assumes an 8-bit register address and 8-bit register data.
`ifndef MOTOR_OPT_DEFS_SVH
`define MOTOR_OPT_DEFS_SVH

`define OFF_CURRENT_LIMIT 8'h28
`define OFF_CL_TIMING 8'h29
`define OFF_SENSE 8'h2a
`define OFF_TACH_INPUT 8'h2b

`define RST_CURRENT_LIMIT 8'h00
`define RST_CL_TIMING 8'h00
`define RST_SENSE 8'h00
`define RST_TACH_INPUT 8'h00

`define CURRENT_LIMIT_WMASK 8'hfe

`define ACCEL_CAP_MSB 7
`define ACCEL_CAP_LSB 4
`define LOCK_CAP_MSB 3
`define LOCK_CAP_LSB 1
`define CL_STUCK_EN_BIT 7
`define SLEW_MSB 6
`define SLEW_LSB 4
`define DEAD_MSB 3
`define DEAD_LSB 0
`define SENSE_THR_MSB 7
`define SENSE_THR_LSB 4
`define OL_STUCK_EN_BIT 3
`define REG_LEVEL_BIT 2
`define SENSE_RATE_MSB 1
`define SENSE_RATE_LSB 0
`define TACH_GATE_MSB 7
`define TACH_GATE_LSB 6
`define TACH_DIV_MSB 5
`define TACH_DIV_LSB 4
`define TORQUE_UPPER_BIT 2
`define TORQUE_LOWER_BIT 3
`define SPEED_PWM_BIT 1
`define CL_INHIBIT_BIT 0

`define ACCEL_STEP_MA 200
`define LOCK_STEP_MA 400
`define SENSE_STEP_MA 200
`define DEAD_STEP_NS 40
`define CLK_PERIOD_NS 25

`endif

// >>> rtl/motor_opt_pkg.sv
// Types shared by the option register bank and its tach pulse stage.
// Assumes the constants header is compiled alongside.
`default_nettype none

package motor_opt_pkg;

    typedef enum logic [1:0] {
        TACH_GATE_BOTH = 2'b00,
        TACH_GATE_CLOSED = 2'b01,
        TACH_GATE_CLOSED_FIRST_OPEN = 2'b10,
        TACH_GATE_SPARE = 2'b11
    } tach_gate_t;

    typedef enum logic [1:0] {
        TACH_DIV_ONE = 2'b00,
        TACH_DIV_TWO_OF_THREE = 2'b01,
        TACH_DIV_HALF = 2'b10,
        TACH_DIV_SPARE = 2'b11
    } tach_div_t;

endpackage

`default_nettype wire

// >>> rtl/tach_cfg_if.sv
// Carries the tach configuration fields from the register bank to the tach stage.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none

interface tach_cfg_if;
    import motor_opt_pkg::*;
    tach_gate_t gate;
    tach_div_t div;

    modport source (output gate, output div);
    modport sink (input gate, input div);
endinterface

`default_nettype wire

// >>> rtl/tach_pulse_stage.sv
// Gates and scales electrical cycle pulses into tach output pulses.
// Assumes cycle and loop-state inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module tach_pulse_stage
    import motor_opt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    tach_cfg_if.sink cfg,
    input wire logic elec_cycle,
    input wire logic in_closed_loop,
    input wire logic in_first_open_loop,
    output logic tach_output
);

    logic [1:0] cycle_q;
    logic [1:0] cycle_d;
    logic tach_q;
    logic tach_d;
    logic loop_ok;
    logic div_ok;

    always_comb begin
        unique case (cfg.gate)
            TACH_GATE_CLOSED: loop_ok = in_closed_loop;
            TACH_GATE_CLOSED_FIRST_OPEN: loop_ok = in_closed_loop | in_first_open_loop;
            default: loop_ok = 1'b1;
        endcase
        unique case (cfg.div)
            TACH_DIV_TWO_OF_THREE: div_ok = (cycle_q != 2'h2);
            TACH_DIV_HALF: div_ok = (cycle_q == 2'h0);
            default: div_ok = 1'b1;
        endcase
        cycle_d = cycle_q;
        if (elec_cycle && loop_ok) begin
            if ((cfg.div == TACH_DIV_TWO_OF_THREE && cycle_q == 2'h2)
                || (cfg.div == TACH_DIV_HALF && cycle_q == 2'h1)
                || cfg.div == TACH_DIV_ONE || cfg.div == TACH_DIV_SPARE) begin
                cycle_d = 2'h0;
            end else begin
                cycle_d = cycle_q + 2'h1;
            end
        end
        tach_d = elec_cycle & loop_ok & div_ok;
        if (!resetn) begin
            cycle_d = 2'h0;
            tach_d = 1'b0;
        end
    end

    // Reset travels through the next values, so a low enable holds off reset as well.
    always_ff @(posedge clk) begin
        if (ce) begin
            cycle_q <= cycle_d;
            tach_q <= tach_d;
        end
    end

    assign tach_output = tach_q;

endmodule

`default_nettype wire

// >>> rtl/motor_drive_option_regs.sv
// Option register bank of a sensorless three-phase motor driver.
// Assumes the serial host port engine drives the register port on this clock.
//
// Summary of operation
// - Acceleration cap: zero off, else n*0.2A.
// - Lock current cap is (n+1)*0.4A.
// - Bit 7 enables closed-loop stuck detection.
// - Slew code 000 unlimited, higher codes slower.
// - Dead time is (n+1)*40 ns.
// - Sense threshold zero means align then go.
// - Bit 3 enables open-loop stuck detection.
// - Bit 2 selects 3.3 V, else 5 V.
// - Tach gating by loop state code.
// - Tach pulses scaled per electrical cycle code.
// - Bit 2 upper bound, bit 3 lower bound.
// - Bit 1 selects pulse-width speed input.
// - Bit 0 high keeps the motor open loop.
`timescale 1ns/1ps
`default_nettype none
`include "motor_opt_defs.svh"

module motor_drive_option_regs
    import motor_opt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_hit,
    output logic accel_cap_enable,
    output logic [11:0] accel_current_cap_ma,
    output logic [11:0] lock_current_cap_ma,
    output logic closed_loop_stuck_enable,
    output logic open_loop_stuck_enable,
    output logic closed_loop_slew_unlimited,
    output logic [2:0] closed_loop_slew,
    output logic [9:0] dead_time_ns,
    output logic [5:0] dead_time_cycles,
    output logic inductive_position_sense,
    output logic [11:0] position_sense_threshold_ma,
    output logic [1:0] position_sense_rate,
    output logic regulator_level_select,
    output logic torque_constant_upper_double,
    output logic torque_constant_lower_half,
    output logic speed_input_type,
    output logic closed_loop_inhibit,
    input wire logic open_to_closed_speed,
    output logic enter_closed_loop,
    input wire logic elec_cycle,
    input wire logic in_closed_loop,
    input wire logic in_first_open_loop,
    output logic tach_output
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage and host access.

    logic [7:0] cur_q, cur_d;
    logic [7:0] clt_q, clt_d;
    logic [7:0] sen_q, sen_d;
    logic [7:0] tin_q, tin_d;
    logic [7:0] rd_q, rd_d;
    logic hit_q, hit_d;

    always_comb begin
        cur_d = cur_q;
        clt_d = clt_q;
        sen_d = sen_q;
        tin_d = tin_q;
        rd_d = rd_q;
        hit_d = 1'b0;
        if (!resetn) begin
            cur_d = `RST_CURRENT_LIMIT;
            clt_d = `RST_CL_TIMING;
            sen_d = `RST_SENSE;
            tin_d = `RST_TACH_INPUT;
            rd_d = 8'h00;
        end else begin
            if (reg_wr_en) begin
                unique case (reg_addr)
                    `OFF_CURRENT_LIMIT: cur_d = reg_wr_data & `CURRENT_LIMIT_WMASK;
                    `OFF_CL_TIMING: clt_d = reg_wr_data;
                    `OFF_SENSE: sen_d = reg_wr_data;
                    `OFF_TACH_INPUT: tin_d = reg_wr_data;
                    default: ;
                endcase
            end
            if (reg_rd_en) begin
                hit_d = 1'b1;
                unique case (reg_addr)
                    `OFF_CURRENT_LIMIT: rd_d = cur_q & `CURRENT_LIMIT_WMASK;
                    `OFF_CL_TIMING: rd_d = clt_q;
                    `OFF_SENSE: rd_d = sen_q;
                    `OFF_TACH_INPUT: rd_d = tin_q;
                    default: begin
                        rd_d = 8'h00;
                        hit_d = 1'b0;
                    end
                endcase
            end
        end
    end

    // Reset travels through the next values, so a low enable holds off reset as well.
    always_ff @(posedge clk) begin
        if (ce) begin
            cur_q <= cur_d;
            clt_q <= clt_d;
            sen_q <= sen_d;
            tin_q <= tin_d;
            rd_q <= rd_d;
            hit_q <= hit_d;
        end
    end

    assign reg_rd_data = rd_q;
    assign reg_rd_hit = hit_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Field decode into engine-facing settings.

    // Settings are decoded from the next register values, so they change on the same edge
    // as the registers while still leaving the block from flip-flops.

    logic [3:0] accel_n, dead_n, sense_n;
    logic [2:0] lock_n;
    logic accel_en_q, accel_en_d;
    logic [11:0] accel_cap_q, accel_cap_d;
    logic [11:0] lock_cap_q, lock_cap_d;
    logic cl_stuck_q, cl_stuck_d;
    logic ol_stuck_q, ol_stuck_d;
    logic slew_unl_q, slew_unl_d;
    logic [2:0] slew_q, slew_d;
    logic [9:0] dead_ns_q, dead_ns_d;
    logic [5:0] dead_cyc_q, dead_cyc_d;
    logic sense_en_q, sense_en_d;
    logic [11:0] sense_thr_q, sense_thr_d;
    logic [1:0] sense_rate_q, sense_rate_d;
    logic reg_level_q, reg_level_d;
    logic upper_double_q, upper_double_d;
    logic lower_half_q, lower_half_d;
    logic speed_pwm_q, speed_pwm_d;
    logic cl_inhibit_q, cl_inhibit_d;

    always_comb begin
        accel_n = cur_d[`ACCEL_CAP_MSB:`ACCEL_CAP_LSB];
        lock_n = cur_d[`LOCK_CAP_MSB:`LOCK_CAP_LSB];
        dead_n = clt_d[`DEAD_MSB:`DEAD_LSB];
        sense_n = sen_d[`SENSE_THR_MSB:`SENSE_THR_LSB];
        accel_en_d = (accel_n != 4'h0);
        accel_cap_d = 12'(32'(accel_n) * `ACCEL_STEP_MA);
        lock_cap_d = 12'((32'(lock_n) + 32'd1) * `LOCK_STEP_MA);
        cl_stuck_d = clt_d[`CL_STUCK_EN_BIT];
        slew_d = clt_d[`SLEW_MSB:`SLEW_LSB];
        slew_unl_d = (slew_d == 3'h0);
        dead_ns_d = 10'((32'(dead_n) + 32'd1) * `DEAD_STEP_NS);
        // Gap is a least time, so the cycle count rounds up.
        dead_cyc_d = 6'((32'(dead_ns_d) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
        sense_en_d = (sense_n != 4'h0);
        sense_thr_d = 12'h000;
        if (sense_en_d) begin
            sense_thr_d = 12'((32'(sense_n) + 32'd1) * `SENSE_STEP_MA);
        end
        ol_stuck_d = sen_d[`OL_STUCK_EN_BIT];
        reg_level_d = sen_d[`REG_LEVEL_BIT];
        sense_rate_d = sen_d[`SENSE_RATE_MSB:`SENSE_RATE_LSB];
        upper_double_d = tin_d[`TORQUE_UPPER_BIT];
        lower_half_d = tin_d[`TORQUE_LOWER_BIT];
        speed_pwm_d = tin_d[`SPEED_PWM_BIT];
        cl_inhibit_d = tin_d[`CL_INHIBIT_BIT];
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            accel_en_q <= accel_en_d;
            accel_cap_q <= accel_cap_d;
            lock_cap_q <= lock_cap_d;
            cl_stuck_q <= cl_stuck_d;
            ol_stuck_q <= ol_stuck_d;
            slew_unl_q <= slew_unl_d;
            slew_q <= slew_d;
            dead_ns_q <= dead_ns_d;
            dead_cyc_q <= dead_cyc_d;
            sense_en_q <= sense_en_d;
            sense_thr_q <= sense_thr_d;
            sense_rate_q <= sense_rate_d;
            reg_level_q <= reg_level_d;
            upper_double_q <= upper_double_d;
            lower_half_q <= lower_half_d;
            speed_pwm_q <= speed_pwm_d;
            cl_inhibit_q <= cl_inhibit_d;
        end
    end

    assign accel_cap_enable = accel_en_q;
    assign accel_current_cap_ma = accel_cap_q;
    assign lock_current_cap_ma = lock_cap_q;
    assign closed_loop_stuck_enable = cl_stuck_q;
    assign open_loop_stuck_enable = ol_stuck_q;
    assign closed_loop_slew_unlimited = slew_unl_q;
    assign closed_loop_slew = slew_q;
    assign dead_time_ns = dead_ns_q;
    assign dead_time_cycles = dead_cyc_q;
    assign inductive_position_sense = sense_en_q;
    assign position_sense_threshold_ma = sense_thr_q;
    assign position_sense_rate = sense_rate_q;
    assign regulator_level_select = reg_level_q;
    assign torque_constant_upper_double = upper_double_q;
    assign torque_constant_lower_half = lower_half_q;
    assign speed_input_type = speed_pwm_q;
    assign closed_loop_inhibit = cl_inhibit_q;
    assign enter_closed_loop = open_to_closed_speed & ~closed_loop_inhibit;

    ////////////////////////////////////////////////////////////////////////////////
    // Tach pulse output.

    tach_cfg_if tach_cfg ();

    assign tach_cfg.gate = tach_gate_t'(tin_q[`TACH_GATE_MSB:`TACH_GATE_LSB]);
    assign tach_cfg.div = tach_div_t'(tin_q[`TACH_DIV_MSB:`TACH_DIV_LSB]);

    tach_pulse_stage u_tach (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .cfg(tach_cfg.sink),
        .elec_cycle(elec_cycle),
        .in_closed_loop(in_closed_loop),
        .in_first_open_loop(in_first_open_loop),
        .tach_output(tach_output)
    );

endmodule

`default_nettype wire

// >>> verification/motor_drive_option_regs_props.sv
// Checker for the option register bank, seeing only its ports.
// Assumes it is bound to every instance of the bank.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module motor_drive_option_regs_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_hit,
    input wire logic accel_cap_enable,
    input wire logic [11:0] accel_current_cap_ma,
    input wire logic [11:0] lock_current_cap_ma,
    input wire logic closed_loop_slew_unlimited,
    input wire logic [2:0] closed_loop_slew,
    input wire logic open_to_closed_speed,
    input wire logic closed_loop_inhibit,
    input wire logic enter_closed_loop,
    input wire logic elec_cycle,
    input wire logic tach_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic rd = ce && reg_rd_en;
    wire logic mapped = reg_addr[7:2] == 6'h0a;
    property p_accel; accel_cap_enable == (accel_current_cap_ma != 12'h000); endproperty
    a_accel: assert property (p_accel) else $error("accel enable wrong");
    property p_wr_cap;
        ce && reg_wr_en && reg_addr == 8'h28
            |=> accel_current_cap_ma == $past(reg_wr_data[7:4]) * 12'h0c8;
    endproperty
    a_wr_cap: assert property (p_wr_cap) else $error("accel cap wrong");
    property p_lock;
        lock_current_cap_ma % 12'h190 == 12'h000
            && lock_current_cap_ma inside {[12'h190:12'hc80]};
    endproperty
    a_lock: assert property (p_lock) else $error("lock cap wrong");
    property p_slew; closed_loop_slew_unlimited == (closed_loop_slew == 3'h0); endproperty
    a_slew: assert property (p_slew) else $error("slew flag wrong");
    property p_enter;
        enter_closed_loop == (open_to_closed_speed && !closed_loop_inhibit);
    endproperty
    a_enter: assert property (p_enter) else $error("closed loop entry wrong");
    property p_bit0; rd && reg_addr == 8'h28 |=> reg_rd_hit && !reg_rd_data[0]; endproperty
    a_bit0: assert property (p_bit0) else $error("unused bit read high");
    property p_hit; rd && mapped |=> reg_rd_hit; endproperty
    a_hit: assert property (p_hit) else $error("mapped read not hit");
    property p_unmap; rd && !mapped |=> !reg_rd_hit && reg_rd_data == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read answered");
    property p_tach; tach_output && $past(ce) |-> $past(elec_cycle); endproperty
    a_tach: assert property (p_tach) else $error("tach pulse without cycle");
    c_hit: cover property (rd && mapped ##1 reg_rd_hit);
    c_tach: cover property (tach_output);
    c_enter: cover property (enter_closed_loop);
endmodule
bind motor_drive_option_regs motor_drive_option_regs_props u_props (
    .clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_hit(reg_rd_hit), .accel_cap_enable(accel_cap_enable),
    .accel_current_cap_ma(accel_current_cap_ma), .lock_current_cap_ma(lock_current_cap_ma),
    .closed_loop_slew_unlimited(closed_loop_slew_unlimited),
    .closed_loop_slew(closed_loop_slew), .open_to_closed_speed(open_to_closed_speed),
    .closed_loop_inhibit(closed_loop_inhibit), .enter_closed_loop(enter_closed_loop),
    .elec_cycle(elec_cycle), .tach_output(tach_output)
);
`default_nettype wire

// >>> verification/motor_drive_option_regs_tb_top.sv
// Self-checking bench for the option register bank.
// Assumes the bank and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module motor_drive_option_regs_tb_top;
    logic clk = 0, resetn = 0, ce = 1, wr = 0, rd = 0;
    logic ots = 0, ec = 0, icl = 0, ifo = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00;
    wire logic [7:0] rdd;
    wire logic hit, ace, cse, ose, slu, ips, rls, tu, tl, sit, cli, ecl, tach;
    wire logic [11:0] acc, lck, thr;
    wire logic [9:0] dns;
    wire logic [5:0] dcy;
    wire logic [2:0] slw;
    wire logic [1:0] psr;
    int bad_count = 0, tests_run = 0, seen = 0, cyc = 0;
    motor_drive_option_regs dut (
        .clk(clk), .resetn(resetn), .ce(ce), .reg_addr(addr), .reg_wr_en(wr),
        .reg_wr_data(wd), .reg_rd_en(rd), .reg_rd_data(rdd), .reg_rd_hit(hit),
        .accel_cap_enable(ace), .accel_current_cap_ma(acc), .lock_current_cap_ma(lck),
        .closed_loop_stuck_enable(cse), .open_loop_stuck_enable(ose),
        .closed_loop_slew_unlimited(slu), .closed_loop_slew(slw), .dead_time_ns(dns),
        .dead_time_cycles(dcy), .inductive_position_sense(ips),
        .position_sense_threshold_ma(thr), .position_sense_rate(psr),
        .regulator_level_select(rls), .torque_constant_upper_double(tu),
        .torque_constant_lower_half(tl), .speed_input_type(sit),
        .closed_loop_inhibit(cli), .open_to_closed_speed(ots), .enter_closed_loop(ecl),
        .elec_cycle(ec), .in_closed_loop(icl), .in_first_open_loop(ifo), .tach_output(tach)
    );
    always #12.5 clk = ~clk;
    // The run is a few hundred cycles; the ceiling leaves wide margin.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            wrap_up();
        end
    end
    task wrap_up();
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task rst();
        resetn = 0;
        repeat (6) @(negedge clk);
        resetn = 1;
    endtask
    task w(input logic [7:0] a, d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task r(input logic [7:0] a, e, input logic h);
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        chk("read", {h, e}, {hit, rdd});
    endtask
    // Six cycles bring every divider phase back to its start.
    task tc(input logic [7:0] v, input logic c, f, input int n);
        rst();
        w(8'h2b, v);
        icl = c;
        ifo = f;
        seen = 0;
        repeat (6) begin
            @(negedge clk) ec = 1;
            @(negedge clk) ec = 0;
            if (tach === 1'b1) seen++;
            @(negedge clk);
            if (tach === 1'b1) seen++;
        end
        @(negedge clk);
        chk("tach", n, seen);
    endtask
    ////////////////////////////////////////
    initial begin
        rst();
        for (int i = 8'h28; i < 8'h2c; i++) r(i[7:0], 8'h00, 1'b1);
        w(8'h28, 8'hff);
        r(8'h28, 8'hfe, 1'b1);
        chk("cap", {1'b1, 12'd3000, 12'd3200}, {ace, acc, lck});
        w(8'h28, 8'h10);
        chk("cap1", {1'b1, 12'd200, 12'd400}, {ace, acc, lck});
        w(8'h28, 8'h00);
        chk("cap0", 1'b0, ace);
        ce = 0;
        w(8'h28, 8'h50);
        ce = 1;
        chk("freeze", 12'd0, acc);
        w(8'h29, 8'h85);
        chk("cl", {2'b11, 3'd0, 10'd240, 6'd10}, {cse, slu, slw, dns, dcy});
        w(8'h29, 8'h7f);
        chk("cl2", {2'b00, 3'd7, 10'd640, 6'd26}, {cse, slu, slw, dns, dcy});
        w(8'h2a, 8'h0c);
        chk("ips0", {13'd0, 4'b1100}, {ips, thr, ose, rls, psr});
        w(8'h2a, 8'h13);
        chk("ips1", {1'b1, 12'd400, 4'b0011}, {ips, thr, ose, rls, psr});
        ots = 1;
        for (int i = 0; i < 16; i++) begin
            w(8'h2b, i[7:0]);
            chk("opt", {i[3:0], ~i[0]}, {tl, tu, sit, cli, ecl});
        end
        r(8'h30, 8'h00, 1'b0);
        r(8'h27, 8'h00, 1'b0);
        tc(8'h00, 0, 0, 6);
        tc(8'h40, 0, 0, 0);
        tc(8'h50, 1, 0, 4);
        tc(8'ha0, 0, 1, 3);
        tc(8'h80, 0, 0, 0);
        tc(8'hf0, 0, 0, 6);
        wrap_up();
    end
endmodule
`default_nettype wire
